// >>> rtl/clk_cfg_pkg.sv
package clk_cfg_pkg;

  localparam logic [7:0]  POWER_SAVE_CLOCK_CONTROL_OFFSET = 8'hF0;
  localparam logic [7:0]  RESET_STRAP_CAPTURE_OFFSET      = 8'hF6;

  localparam int          POWER_SAVE_ENABLE_BIT           = 15;
  localparam int          SECOND_FREQ_SEL_BIT             = 11;
  localparam int          SECOND_DISABLE_BIT              = 10;
  localparam int          FIRST_FREQ_SEL_BIT              = 9;
  localparam int          FIRST_DISABLE_BIT               = 8;
  localparam int          DIVISOR_SELECT_LSB              = 0;
  localparam int          DIVISOR_SELECT_W                = 3;

  localparam logic [15:0] POWER_SAVE_CLOCK_CONTROL_RESET  = 16'h0000;
  localparam logic [15:0] RESET_STRAP_CAPTURE_RESET       = 16'h0000;

  // least reset pulse, in oscillator periods (one clk period each)
  localparam int          RESET_MIN_OSC_PERIODS           = 7;

  localparam int          SHIFT_W                         = 4;
  localparam int          DIV_CNT_W                       = 8;
  localparam logic [3:0]  HALVE_SHIFT                     = 4'h1;

  typedef struct packed {
    logic [DIV_CNT_W-1:0] cnt;
    logic [SHIFT_W-1:0]   shift;
    logic                 tick;
  } div_state_s;

  typedef struct packed {
    logic                        power_save_enable;
    logic                        second_clock_out_freq_sel;
    logic                        second_clock_out_disable;
    logic                        first_clock_out_freq_sel;
    logic                        first_clock_out_disable;
    logic [DIVISOR_SELECT_W-1:0] divisor_select;
    logic [15:0]                 reset_config_bits;
    logic                        strap_done;
    logic                        pin_float_test_mode;
    logic                        halve_clock;
    logic                        address_phase_suppress;
    logic                        xtal_phase;
    logic                        div_phase;
    logic                        cpu_tick;
    logic                        first_clock_output;
    logic                        first_clock_output_oe_n;
    logic                        second_clock_output;
    logic                        second_clock_output_oe_n;
    logic [15:0]                 rdata;
  } top_state_s;

endpackage

// >>> rtl/clock_divider.sv
`timescale 1ns/1ns
module clock_divider (
  input  wire logic                          clk,
  input  wire logic                          resetn,
  input  wire logic [clk_cfg_pkg::SHIFT_W-1:0] shift_req,
  output logic                               tick,
  output logic      [clk_cfg_pkg::SHIFT_W-1:0] shift_now
);

  clk_cfg_pkg::div_state_s state_reg;
  clk_cfg_pkg::div_state_s state_next;
  logic [8:0]              period;

  always_comb begin
    period           = 9'h001 << shift_req;
    state_next       = state_reg;
    state_next.tick  = 1'b0;
    if (state_reg.cnt == 8'h00) begin
      // new divisor only taken at a period boundary, no short pulse
      state_next.tick  = 1'b1;
      state_next.shift = shift_req;
      state_next.cnt   = 8'(period - 9'h001);
    end else begin
      state_next.cnt = state_reg.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign tick      = state_reg.tick;
  assign shift_now = state_reg.shift;

  // helper: cycles since last tick and the divisor that governed them
  logic [8:0]                    gap_reg;
  logic [clk_cfg_pkg::SHIFT_W-1:0] prev_shift_reg;
  logic                          seen_reg;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gap_reg        <= 9'h000;
      prev_shift_reg <= 4'h0;
      seen_reg       <= 1'b0;
    end else if (tick) begin
      gap_reg        <= 9'h001;
      prev_shift_reg <= shift_now;
      seen_reg       <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 9'h001;
    end
  end

  a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
    tick && seen_reg |-> gap_reg == (9'h001 << prev_shift_reg))
    else $error("divided clock period does not match divisor");

  a_shift_boundary: assert property (@(posedge clk) disable iff (!resetn)
    !tick |-> $stable(shift_now))
    else $error("divisor changed away from a period boundary");

endmodule

// >>> rtl/clock_powersave_reset_config.sv
`timescale 1ns/1ns
module clock_powersave_reset_config (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        ext_interrupt,
  input  wire logic        soft_interrupt,
  input  wire logic        exception_taken,
  input  wire logic [15:0] muxed_addr_data_bus_in,
  input  wire logic        upper_memory_select_strap_n,
  input  wire logic        lower_memory_select_strap_n,
  input  wire logic        halve_clock_strap_n,
  input  wire logic        address_phase_strap_n,
  output logic             power_save_enable,
  output logic             cpu_clock_tick,
  output logic             first_clock_output,
  output logic             first_clock_output_oe_n,
  output logic             second_clock_output,
  output logic             second_clock_output_oe_n,
  output logic             pin_float_test_mode,
  output logic             address_phase_suppress
);

  clk_cfg_pkg::top_state_s         state_reg;
  clk_cfg_pkg::top_state_s         state_next;
  logic [clk_cfg_pkg::SHIFT_W-1:0] shift_req;
  logic [clk_cfg_pkg::SHIFT_W-1:0] shift_now;
  logic                            div_tick;
  logic                            ctrl_wr;
  logic [15:0]                     ctrl_view;

  always_comb begin
    // divide by 2**code while power-save is on, plus one step when halved
    shift_req = (state_reg.power_save_enable ?
                 {1'b0, state_reg.divisor_select} : 4'h0) +
                (state_reg.halve_clock ? clk_cfg_pkg::HALVE_SHIFT : 4'h0);
  end

  clock_divider u_divider (
    .clk       (clk),
    .resetn    (resetn),
    .shift_req (shift_req),
    .tick      (div_tick),
    .shift_now (shift_now)
  );

  always_comb begin
    ctrl_view = 16'h0000;
    ctrl_view[clk_cfg_pkg::POWER_SAVE_ENABLE_BIT] = state_reg.power_save_enable;
    ctrl_view[clk_cfg_pkg::SECOND_FREQ_SEL_BIT]   = state_reg.second_clock_out_freq_sel;
    ctrl_view[clk_cfg_pkg::SECOND_DISABLE_BIT]    = state_reg.second_clock_out_disable;
    ctrl_view[clk_cfg_pkg::FIRST_FREQ_SEL_BIT]    = state_reg.first_clock_out_freq_sel;
    ctrl_view[clk_cfg_pkg::FIRST_DISABLE_BIT]     = state_reg.first_clock_out_disable;
    ctrl_view[clk_cfg_pkg::DIVISOR_SELECT_LSB +: clk_cfg_pkg::DIVISOR_SELECT_W] =
      state_reg.divisor_select;
  end

  assign ctrl_wr = reg_wr && (reg_addr == clk_cfg_pkg::POWER_SAVE_CLOCK_CONTROL_OFFSET);

  always_comb begin
    state_next = state_reg;

    if (ctrl_wr) begin
      state_next.power_save_enable =
        reg_wdata[clk_cfg_pkg::POWER_SAVE_ENABLE_BIT];
      state_next.second_clock_out_freq_sel =
        reg_wdata[clk_cfg_pkg::SECOND_FREQ_SEL_BIT];
      state_next.second_clock_out_disable =
        reg_wdata[clk_cfg_pkg::SECOND_DISABLE_BIT];
      state_next.first_clock_out_freq_sel =
        reg_wdata[clk_cfg_pkg::FIRST_FREQ_SEL_BIT];
      state_next.first_clock_out_disable =
        reg_wdata[clk_cfg_pkg::FIRST_DISABLE_BIT];
      state_next.divisor_select =
        reg_wdata[clk_cfg_pkg::DIVISOR_SELECT_LSB +: clk_cfg_pkg::DIVISOR_SELECT_W];
    end
    // soft interrupts and exceptions do not touch the enable
    if (ext_interrupt) begin
      state_next.power_save_enable = 1'b0;
    end

    // straps and bus value caught once, on the first edge after reset release
    if (!state_reg.strap_done) begin
      state_next.strap_done             = 1'b1;
      state_next.reset_config_bits      = muxed_addr_data_bus_in;
      state_next.pin_float_test_mode    = !upper_memory_select_strap_n &&
                                          !lower_memory_select_strap_n;
      state_next.halve_clock            = !halve_clock_strap_n;
      state_next.address_phase_suppress = !address_phase_strap_n;
    end

    state_next.cpu_tick   = div_tick;
    state_next.xtal_phase = !state_reg.xtal_phase;
    state_next.div_phase  = state_reg.div_phase ^ div_tick;

    state_next.first_clock_output = state_reg.first_clock_out_freq_sel ?
                                    state_next.xtal_phase : state_next.div_phase;
    state_next.second_clock_output = state_reg.second_clock_out_freq_sel ?
                                     state_next.xtal_phase : state_next.div_phase;
    // float flag taken from the next state, so no driven cycle follows the strap capture
    state_next.first_clock_output_oe_n = state_reg.first_clock_out_disable ||
                                         state_next.pin_float_test_mode;
    state_next.second_clock_output_oe_n = state_reg.second_clock_out_disable ||
                                          state_next.pin_float_test_mode;

    if (reg_rd) begin
      unique case (reg_addr)
        clk_cfg_pkg::POWER_SAVE_CLOCK_CONTROL_OFFSET: state_next.rdata = ctrl_view;
        clk_cfg_pkg::RESET_STRAP_CAPTURE_OFFSET:
          state_next.rdata = state_reg.reset_config_bits;
        default: state_next.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg                          <= '0;
      state_reg.power_save_enable        <=
        clk_cfg_pkg::POWER_SAVE_CLOCK_CONTROL_RESET[clk_cfg_pkg::POWER_SAVE_ENABLE_BIT];
      state_reg.divisor_select           <= clk_cfg_pkg::POWER_SAVE_CLOCK_CONTROL_RESET[
        clk_cfg_pkg::DIVISOR_SELECT_LSB +: clk_cfg_pkg::DIVISOR_SELECT_W];
      state_reg.reset_config_bits        <= clk_cfg_pkg::RESET_STRAP_CAPTURE_RESET;
      state_reg.first_clock_output_oe_n  <= 1'b1;
      state_reg.second_clock_output_oe_n <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign reg_rdata                = state_reg.rdata;
  assign power_save_enable        = state_reg.power_save_enable;
  assign cpu_clock_tick           = state_reg.cpu_tick;
  assign first_clock_output       = state_reg.first_clock_output;
  assign first_clock_output_oe_n  = state_reg.first_clock_output_oe_n;
  assign second_clock_output      = state_reg.second_clock_output;
  assign second_clock_output_oe_n = state_reg.second_clock_output_oe_n;
  assign pin_float_test_mode      = state_reg.pin_float_test_mode;
  assign address_phase_suppress   = state_reg.address_phase_suppress;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_release;
    !state_reg.strap_done ##1 state_reg.strap_done;
  endsequence

  a_ext_int_wake: assert property (
    ext_interrupt |=> !power_save_enable && (shift_req == {3'h0, state_reg.halve_clock}))
    else $error("external interrupt did not leave power-save");

  a_soft_int_keep: assert property (
    (soft_interrupt || exception_taken) && !ext_interrupt && !ctrl_wr
      |=> $stable(power_save_enable))
    else $error("software interrupt changed power-save enable");

  a_full_rate_tick: assert property (
    (shift_now == 4'h0)[*2] |=> cpu_clock_tick)
    else $error("undivided clock missed a tick");

  a_second_xtal: assert property (
    state_reg.second_clock_out_freq_sel ##1 state_reg.second_clock_out_freq_sel
      |=> second_clock_output != $past(second_clock_output))
    else $error("second clock output not at crystal rate");

  a_second_float: assert property (
    state_reg.second_clock_out_disable |=> second_clock_output_oe_n)
    else $error("second clock output driven while disabled");

  a_first_divided: assert property (
    !state_reg.first_clock_out_freq_sel ##1 (!state_reg.first_clock_out_freq_sel && !div_tick)
      |=> $stable(first_clock_output))
    else $error("first clock output moved without an internal tick");

  a_first_float: assert property (
    state_reg.first_clock_out_disable || pin_float_test_mode |=> first_clock_output_oe_n)
    else $error("first clock output driven while disabled");

  a_strap_capture: assert property (
    s_release |-> state_reg.reset_config_bits == $past(muxed_addr_data_bus_in))
    else $error("bus straps not captured at reset release");

  a_config_hold: assert property (
    state_reg.strap_done |=> $stable(state_reg.reset_config_bits))
    else $error("configuration register changed after capture");

  a_float_strap: assert property (
    s_release |-> pin_float_test_mode ==
      $past(!upper_memory_select_strap_n && !lower_memory_select_strap_n))
    else $error("float test mode strap misread");

  a_halve_strap: assert property (
    s_release |-> state_reg.halve_clock == $past(!halve_clock_strap_n))
    else $error("halving strap misread");

  a_addr_strap: assert property (
    s_release |-> address_phase_suppress == $past(!address_phase_strap_n))
    else $error("address phase strap misread");

  a_float_oe: assert property (
    pin_float_test_mode |-> first_clock_output_oe_n && second_clock_output_oe_n)
    else $error("clock output driven in float test mode");

  a_strap_flags_hold: assert property (
    state_reg.strap_done |=> $stable(address_phase_suppress) && $stable(pin_float_test_mode))
    else $error("strap flags changed after capture");

  a_capture_read: assert property (
    reg_rd && reg_addr == clk_cfg_pkg::RESET_STRAP_CAPTURE_OFFSET
      |=> reg_rdata == $past(state_reg.reset_config_bits))
    else $error("configuration register read returned a wrong value");

  a_first_xtal: assert property (
    state_reg.first_clock_out_freq_sel ##1 state_reg.first_clock_out_freq_sel
      |=> first_clock_output != $past(first_clock_output))
    else $error("first clock output not at crystal rate");

endmodule

// >>> tb/strap_source.sv
`timescale 1ns/1ns
// far side: reset circuit plus strap resistors on the bus and select pins
module strap_source (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [19:0] cfg,
  output logic             resetn,
  output logic      [15:0] bus,
  output logic             upper_sel_n,
  output logic             lower_sel_n,
  output logic             halve_n,
  output logic             aphase_n
);
  always begin
    resetn = 1'b0;
    {upper_sel_n, lower_sel_n, halve_n, aphase_n, bus} = cfg;
    repeat (8) @(posedge clk);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clk);
    // pins now carry bus traffic, so a stale capture would show
    #1 {upper_sel_n, lower_sel_n, halve_n, aphase_n, bus} = ~cfg;
    @(posedge start);
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic        clk       = 1'b0;
  logic        start     = 1'b0;
  logic [19:0] cfg       = 20'hFA5C3;
  logic [7:0]  reg_addr  = 8'h00;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic [15:0] reg_wdata = 16'h0000;
  logic        ext_i     = 1'b0;
  logic        soft_i    = 1'b0;
  logic        exc_i     = 1'b0;
  logic        resetn, upper_sel_n, lower_sel_n, halve_n, aphase_n;
  logic [15:0] bus, reg_rdata;
  logic        save_on, tick, o1, o1_oe_n, o2, o2_oe_n, flt, aps;
  int          bad_count = 0;
  int          n_tests   = 0;

  always #2 clk = ~clk;

  strap_source model (.clk(clk), .start(start), .cfg(cfg), .resetn(resetn), .bus(bus),
    .upper_sel_n(upper_sel_n), .lower_sel_n(lower_sel_n), .halve_n(halve_n),
    .aphase_n(aphase_n));

  clock_powersave_reset_config dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .ext_interrupt(ext_i), .soft_interrupt(soft_i), .exception_taken(exc_i),
    .muxed_addr_data_bus_in(bus), .upper_memory_select_strap_n(upper_sel_n),
    .lower_memory_select_strap_n(lower_sel_n), .halve_clock_strap_n(halve_n),
    .address_phase_strap_n(aphase_n), .power_save_enable(save_on), .cpu_clock_tick(tick),
    .first_clock_output(o1), .first_clock_output_oe_n(o1_oe_n),
    .second_clock_output(o2), .second_clock_output_oe_n(o2_oe_n),
    .pin_float_test_mode(flt), .address_phase_suppress(aps));

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string nm);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk);
    #1 reg_rd = 1'b0;
    @(posedge clk);
    #1 chk(nm, exp, reg_rdata);
  endtask

  function automatic logic sig(input int s);
    return (s == 0) ? tick : (s == 1) ? o1 : o2;
  endfunction

  // cycles between two tick pulses (sel 0) or two pin changes (sel 1, 2)
  task automatic period(input int sel, input int exp);
    int   n;
    int   k;
    logic p;
    logic v;
    p = sig(sel);
    k = 0;
    n = 0;
    while (k < 2 && n < 600) begin
      @(posedge clk);
      #1 v = sig(sel);
      n++;
      if (sel == 0 ? v === 1'b1 : v !== p) begin
        k++;
        if (k == 1) n = 0;
      end
      p = v;
    end
    chk("period", exp[15:0], n[15:0]);
  endtask

  task automatic do_reset(input logic [19:0] v);
    cfg = v;
    start = 1'b1;
    @(posedge clk);
    #1 start = 1'b0;
    repeat (12) @(posedge clk);
    #1;
  endtask

  task automatic t_regs;
    rd(8'hF6, 16'hA5C3, "strap_capture");
    rd(8'hF0, 16'h0000, "control_reset");
    wr(8'hF6, 16'h1234);
    rd(8'hF6, 16'hA5C3, "capture_ro");
    wr(8'hF0, 16'hFFFF);
    rd(8'hF0, 16'h8F07, "control_rw");
    rd(8'hF2, 16'h0000, "unmapped");
    chk("float_off", 16'h0000, {15'h0000, flt});
    chk("suppress_off", 16'h0000, {15'h0000, aps});
    $display("test regs done");
  endtask

  task automatic t_div;
    for (int c = 0; c < 8; c++) begin
      wr(8'hF0, 16'h8000 | 16'(c));
      period(0, 1 << c);
    end
    wr(8'hF0, 16'h0007);
    period(0, 1);
    $display("test divisor done");
  endtask

  task automatic t_irq;
    wr(8'hF0, 16'h8005);
    soft_i = 1'b1;
    exc_i = 1'b1;
    @(posedge clk);
    #1 soft_i = 1'b0;
    exc_i = 1'b0;
    chk("save_kept", 16'h0001, {15'h0000, save_on});
    ext_i = 1'b1;
    @(posedge clk);
    #1 ext_i = 1'b0;
    chk("save_cleared", 16'h0000, {15'h0000, save_on});
    reg_addr = 8'hF0;
    reg_wdata = 16'h8005;
    reg_wr = 1'b1;
    ext_i = 1'b1;
    @(posedge clk);
    #1 reg_wr = 1'b0;
    ext_i = 1'b0;
    chk("save_irq_wins", 16'h0000, {15'h0000, save_on});
    rd(8'hF0, 16'h0005, "control_after_irq");
    period(0, 1);
    $display("test interrupt done");
  endtask

  task automatic t_pins;
    wr(8'hF0, 16'h8202);
    period(1, 1);
    period(2, 4);
    chk("first_oe_n", 16'h0000, {15'h0000, o1_oe_n});
    chk("second_oe_n", 16'h0000, {15'h0000, o2_oe_n});
    wr(8'hF0, 16'h8802);
    period(1, 4);
    period(2, 1);
    wr(8'hF0, 16'h8400);
    chk("first_oe_n", 16'h0000, {15'h0000, o1_oe_n});
    chk("second_oe_n", 16'h0001, {15'h0000, o2_oe_n});
    wr(8'hF0, 16'h8100);
    chk("first_oe_n", 16'h0001, {15'h0000, o1_oe_n});
    chk("second_oe_n", 16'h0000, {15'h0000, o2_oe_n});
    $display("test pins done");
  endtask

  task automatic t_straps;
    do_reset(20'h01234);
    chk("float_on", 16'h0001, {15'h0000, flt});
    chk("suppress_on", 16'h0001, {15'h0000, aps});
    chk("float_oe_n", 16'h0001, {15'h0000, o1_oe_n & o2_oe_n});
    rd(8'hF6, 16'h1234, "strap_capture");
    period(0, 2);
    wr(8'hF0, 16'h8001);
    period(0, 4);
    do_reset(20'h74321);
    chk("float_one_low", 16'h0000, {15'h0000, flt});
    chk("suppress_off", 16'h0000, {15'h0000, aps});
    rd(8'hF0, 16'h0000, "control_reset");
    rd(8'hF6, 16'h4321, "strap_recapture");
    period(0, 1);
    $display("test straps done");
  endtask

  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge clk);
    #1;
    t_regs;
    t_div;
    t_irq;
    t_pins;
    t_straps;
    results;
  end

  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    $display("BAD watchdog expected finish seen timeout");
    results;
  end
endmodule
